// [src/usm_status_ctrl.sv]
// Purpose: Line status, modem handshake and FIFO control of a serial port
// Assumes: Shifters, baud divisor and interrupt encoding live outside
// Notes: Registers reached over classic Wishbone, one word per register
//
// Overview of operation
// - FIFO mode: error flag shows any erroneous character in receive FIFO; else zero.
// - That flag drops once no erroneous characters remain; a status read does not clear it.
// - Transmitter idle only when shift register and holding register/FIFO both empty.
// - Non-FIFO: holding-empty sets on move to shifter; event if enable set.
// - FIFO mode: holding-empty sets when FIFO empties; host write clears it.
// - Line-silence flag marks a character received wholly at spacing level.
// - Missing-stop flag marks a character without a valid stop bit.
// - Parity flag marks a character whose parity bit is wrong.
// - FIFO mode: those three flags describe the character at the FIFO head.
// - Status read clears silence, stop, parity and overrun flags.
// - Overrun sets when unread data is overwritten, or FIFO full loses one.
// - Data-available is one while any unread received character remains.
// - Loopback holds serial output high and feeds receiver from transmitter.
// - Loopback forces modem outputs inactive.
// - Loopback feeds modem status from control bits 0..3 internally.
// - Interrupt pin follows request only while output-enable bit is one and loopback is off.
// - RTS and DTR pins drive inverted control bits 1 and 0.
// - Modem status bits 7..4 show complemented DCD, RI, DSR, CTS pins.
// - DCD, DSR, CTS change flags set on toggle; modem status read clears.
// - Ring-edge flag sets when RI pin rises; modem status read clears.
// - Control bits 7:6 pick receive trigger 1, 4, 8 or 14 bytes.
// - DMA mode 1 selected by bit 3 only while FIFO mode enabled.
// - Bits 2 and 1 reset transmit and receive FIFO counters, self-clearing.
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "usm_defs.svh"
module usm_status_ctrl #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Receive shifter side
  input wire logic rx_valid_i,
  input wire usm_pkg::usm_rx_char_t rx_char_i,
  output logic rx_serial_o,
  // Transmit shifter side
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_take_i,
  input wire logic tx_shift_idle_i,
  input wire logic tx_serial_i,
  // Serial line pins
  input wire logic serial_in_pin_i,
  output logic serial_out_pin_o,
  // Modem pins
  input wire usm_pkg::usm_modem_in_t modem_i,
  output logic rts_n_o,
  output logic dtr_n_o,
  // Interrupt glue
  input wire logic tx_empty_irq_enable_i,
  output logic tx_empty_event_o,
  output logic rx_trigger_o,
  input wire logic irq_req_i,
  output logic irq_o,
  // FIFO mode outputs
  output logic fifo_mode_o,
  output logic dma_mode_o
);
  import usm_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);

  // ==========================================================
  // State and decode
  usm_state_t st;
  usm_state_t next_st;
  logic req;
  logic rd;
  logic wr;
  logic [2:0] idx;
  logic in_map;
  logic data_rd;
  logic data_wr;
  logic fifo_wr;
  logic mctl_wr;
  logic lstat_rd;
  logic mstat_rd;
  logic loop;
  logic [7:0] wdat;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] want,
                               input logic mapped);
    hit = mapped && (a == want);
  endfunction

  assign req = wb_cyc_i && wb_stb_i && !st.ack;
  assign rd = req && !wb_we_i;
  // Only the low byte lane carries register data
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign idx = wb_adr_i[`USM_ADR_IDX_HI:`USM_ADR_IDX_LO];
  assign in_map = (wb_adr_i[`USM_ADR_TOP_HI:`USM_ADR_TOP_LO] == '0)
    && (wb_adr_i[`USM_ADR_IDX_LO-1:0] == '0);
  assign wdat = wb_dat_i[7:0];
  assign data_rd = rd && hit(idx, `USM_IDX_DATA, in_map);
  assign data_wr = wr && hit(idx, `USM_IDX_DATA, in_map);
  assign fifo_wr = wr && hit(idx, `USM_IDX_FIFO, in_map);
  assign mctl_wr = wr && hit(idx, `USM_IDX_MCTL, in_map);
  assign lstat_rd = rd && hit(idx, `USM_IDX_LSTAT, in_map);
  assign mstat_rd = rd && hit(idx, `USM_IDX_MSTAT, in_map);
  assign loop = st.mctl[`USM_MC_LOOP];

  // ==========================================================
  // FIFO control strobes
  logic en_change;
  logic rx_clr;
  logic tx_clr;
  logic [CW-1:0] limit;

  // Toggling FIFO mode flushes both queues so a single slot stays consistent
  assign en_change = fifo_wr && (wdat[`USM_FC_ENABLE] != st.fifo_en);
  assign rx_clr = fifo_wr && (wdat[`USM_FC_RX_CLR] || en_change);
  assign tx_clr = fifo_wr && (wdat[`USM_FC_TX_CLR] || en_change);
  // Non-FIFO mode is the same queue cut down to one holding slot
  assign limit = st.fifo_en ? CW'(DEPTH) : CW'(1);

  // ==========================================================
  // Receive queue
  usm_rx_char_t rx_head;
  logic [CW-1:0] rx_count;
  logic rx_avail;
  logic rx_room;
  logic rx_pop;
  logic rx_push;
  logic rx_overwrite;
  logic rx_lost;

  // Non-FIFO: a new character replaces the unread one
  assign rx_overwrite = !st.fifo_en && rx_valid_i && rx_avail;
  assign rx_pop = (data_rd && rx_avail) || rx_overwrite;
  assign rx_push = rx_valid_i && rx_room && !rx_clr;
  assign rx_lost = rx_overwrite || (st.fifo_en && rx_valid_i && !rx_room);

  usm_fifo #(
    .W($bits(usm_rx_char_t)),
    .DEPTH(DEPTH)
  ) u_rx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(rx_clr),
    .limit_i(limit),
    .push_valid_i(rx_valid_i),
    .push_data_i(rx_char_i),
    .push_ready_o(rx_room),
    .pop_valid_o(rx_avail),
    .pop_ready_i(rx_pop),
    .head_o(rx_head),
    .count_o(rx_count)
  );

  // ==========================================================
  // Transmit queue
  logic [CW-1:0] tx_count;
  logic tx_room;
  logic tx_pop;
  logic tx_push;

  assign tx_pop = tx_valid_o && tx_take_i;
  assign tx_push = data_wr && tx_room && !tx_clr;

  usm_fifo #(
    .W(8),
    .DEPTH(DEPTH)
  ) u_tx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(tx_clr),
    .limit_i(limit),
    .push_valid_i(data_wr),
    .push_data_i(wdat),
    .push_ready_o(tx_room),
    .pop_valid_o(tx_valid_o),
    .pop_ready_i(tx_take_i),
    .head_o(tx_data_o),
    .count_o(tx_count)
  );

  // ==========================================================
  // Line status
  usm_rx_err_t head_err;
  usm_rx_err_t shown_err;
  logic err_in;
  logic err_out;
  logic fifo_err;
  logic tx_idle;
  logic tx_drained;
  logic [7:0] lstat;

  assign head_err = rx_head.err;
  // Flags follow the head character; a status read hides what it already saw
  assign shown_err = rx_avail ? (head_err & ~usm_rx_err_t'(st.reported))
    : usm_rx_err_t'(`USM_RST_ERR);
  assign err_in = rx_push && (rx_char_i.err != '0);
  assign err_out = rx_pop && (head_err != '0);
  // Level of the erroneous-entry count, so a read cannot clear it early
  assign fifo_err = st.fifo_en && (st.err_cnt != '0);
  assign tx_idle = tx_shift_idle_i && (tx_count == '0);
  assign tx_drained = tx_pop && (tx_count == CW'(1));
  assign lstat = {fifo_err, tx_idle, st.thre, shown_err, st.overrun, rx_avail};

  // ==========================================================
  // Modem status
  logic [3:0] ms_now;
  logic [3:0] ms_set;
  logic [7:0] mstat;

  // Order is {dcd, ri, dsr, cts}
  assign ms_now = loop
    ? {st.mctl[`USM_MC_OUT], st.mctl[`USM_MC_LRI], st.mctl[`USM_MC_DTR],
       st.mctl[`USM_MC_RTS]}
    : ~{modem_i.dcd_n, modem_i.ri_n, modem_i.dsr_n, modem_i.cts_n};
  always_comb begin
    ms_set = ms_now ^ st.ms_prev;
    // Ring flag only on the pin rising, which is status falling
    ms_set[`USM_MS_RI] = st.ms_prev[`USM_MS_RI] && !ms_now[`USM_MS_RI];
  end
  assign mstat = {ms_now, st.ms_delta};

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.ack = req;
    next_st.ms_prev = ms_now;
    if (rd) begin
      case (1'b1)
        data_rd: next_st.rdata = rx_head.data;
        lstat_rd: next_st.rdata = lstat;
        mstat_rd: next_st.rdata = mstat;
        hit(idx, `USM_IDX_MCTL, in_map): next_st.rdata = {3'h0, st.mctl};
        default: next_st.rdata = `USM_RST_BYTE;
      endcase
    end
    if (mctl_wr) begin
      next_st.mctl = wdat[`USM_MC_LOOP:0];
    end
    if (fifo_wr) begin
      // Bits 5:4 carry nothing and are dropped here
      next_st.fifo_en = wdat[`USM_FC_ENABLE];
      next_st.dma_sel = wdat[`USM_FC_DMA];
      next_st.trig_sel = wdat[`USM_FC_TRIG_HI:`USM_FC_TRIG_LO];
    end
    // Error-entry count tracks what sits in the receive queue
    if (rx_clr) begin
      next_st.err_cnt = `USM_RST_BYTE;
    end else if (err_in && !err_out) begin
      next_st.err_cnt = st.err_cnt + `USM_ONE_CHAR;
    end else if (err_out && !err_in) begin
      next_st.err_cnt = st.err_cnt - `USM_ONE_CHAR;
    end
    // A new head character brings fresh flags
    if (rx_pop || rx_clr) begin
      next_st.reported = `USM_RST_ERR;
    end else if (lstat_rd) begin
      next_st.reported = st.reported | head_err;
    end
    // Loss in the same cycle as the read still shows
    if (rx_lost) begin
      next_st.overrun = 1'b1;
    end else if (lstat_rd) begin
      next_st.overrun = 1'b0;
    end
    // A host byte outranks the queue draining in the same cycle
    if (tx_push) begin
      next_st.thre = 1'b0;
    end else if (tx_drained || tx_clr) begin
      next_st.thre = 1'b1;
    end
    if (mstat_rd) begin
      next_st.ms_delta = ms_set;
    end else begin
      next_st.ms_delta = st.ms_delta | ms_set;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      next_st_reset();
    end else begin
      st <= next_st;
    end
  end

  task automatic next_st_reset();
    st.ack <= 1'b0;
    st.rdata <= `USM_RST_BYTE;
    st.mctl <= `USM_RST_MCTL;
    st.fifo_en <= 1'b0;
    st.dma_sel <= 1'b0;
    st.trig_sel <= `USM_RST_TRIG;
    st.overrun <= 1'b0;
    st.reported <= `USM_RST_ERR;
    st.thre <= 1'b1;
    st.ms_prev <= `USM_RST_NIB;
    st.ms_delta <= `USM_RST_NIB;
    st.err_cnt <= `USM_RST_BYTE;
  endtask

  // ==========================================================
  // Receive trigger
  logic [7:0] trig_level;

  always_comb begin
    case (st.trig_sel)
      2'h0: trig_level = `USM_TRIG_L0;
      2'h1: trig_level = `USM_TRIG_L1;
      2'h2: trig_level = `USM_TRIG_L2;
      2'h3: trig_level = `USM_TRIG_L3;
      default: trig_level = `USM_TRIG_L0;
    endcase
  end

  assign rx_trigger_o = st.fifo_en ? (8'(rx_count) >= trig_level) : rx_avail;

  // ==========================================================
  // Outputs
  assign wb_ack_o = st.ack;
  assign wb_dat_o = {24'h00_0000, st.rdata};
  assign tx_empty_event_o = tx_drained && !tx_push && tx_empty_irq_enable_i;
  assign fifo_mode_o = st.fifo_en;
  assign dma_mode_o = st.fifo_en && st.dma_sel;
  assign serial_out_pin_o = loop ? 1'b1 : tx_serial_i;
  assign rx_serial_o = loop ? tx_serial_i : serial_in_pin_i;
  assign rts_n_o = loop ? 1'b1 : !st.mctl[`USM_MC_RTS];
  assign dtr_n_o = loop ? 1'b1 : !st.mctl[`USM_MC_DTR];
  // Output-enable bit doubles as the looped carrier, so the pin stays quiet then
  assign irq_o = !loop && st.mctl[`USM_MC_OUT] && irq_req_i;

endmodule

// [src/usm_defs.svh]
// Purpose: Register map, field positions and reset values of the status block
// Assumes: Word-aligned Wishbone registers, byte address = 4 * index
// Notes: Definitions only
`ifndef USM_DEFS_SVH
`define USM_DEFS_SVH

// ==========================================================
// Register indices
`define USM_IDX_DATA 3'h0
`define USM_IDX_FIFO 3'h2
`define USM_IDX_MCTL 3'h4
`define USM_IDX_LSTAT 3'h5
`define USM_IDX_MSTAT 3'h6

// ==========================================================
// Address slicing
`define USM_ADR_IDX_HI 4
`define USM_ADR_IDX_LO 2
`define USM_ADR_TOP_HI 7
`define USM_ADR_TOP_LO 5

// ==========================================================
// Control fields
`define USM_FC_ENABLE 0
`define USM_FC_RX_CLR 1
`define USM_FC_TX_CLR 2
`define USM_FC_DMA 3
`define USM_FC_TRIG_HI 7
`define USM_FC_TRIG_LO 6
`define USM_MC_DTR 0
`define USM_MC_RTS 1
`define USM_MC_LRI 2
`define USM_MC_OUT 3
`define USM_MC_LOOP 4

// ==========================================================
// Modem status index inside the 4-bit group {dcd, ri, dsr, cts}
`define USM_MS_RI 2

// ==========================================================
// Trigger levels and reset values
`define USM_TRIG_L0 8'h01
`define USM_TRIG_L1 8'h04
`define USM_TRIG_L2 8'h08
`define USM_TRIG_L3 8'h0e
`define USM_RST_BYTE 8'h00
`define USM_RST_MCTL 5'h00
`define USM_RST_NIB 4'h0
`define USM_RST_ERR 3'h0
`define USM_RST_TRIG 2'h0
`define USM_ONE_CHAR 8'h01

`endif

// [src/usm_pkg.sv]
// Purpose: Shared types of the status, modem and FIFO control block
// Assumes: Used together with usm_defs.svh
// Notes: Counters sized for FIFO depths up to 255
package usm_pkg;

  // ==========================================================
  // Receive character and its error marks
  typedef struct packed {
    logic silence;
    logic no_stop;
    logic parity;
  } usm_rx_err_t;

  typedef struct packed {
    usm_rx_err_t err;
    logic [7:0] data;
  } usm_rx_char_t;

  // ==========================================================
  // Active-low modem inputs
  typedef struct packed {
    logic dcd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } usm_modem_in_t;

  // ==========================================================
  // Whole state of the main block
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic [4:0] mctl;
    logic fifo_en;
    logic dma_sel;
    logic [1:0] trig_sel;
    logic overrun;
    logic [2:0] reported;
    logic thre;
    logic [3:0] ms_prev;
    logic [3:0] ms_delta;
    logic [7:0] err_cnt;
  } usm_state_t;

endpackage

// [src/usm_fifo.sv]
// Purpose: Small synchronous FIFO with a run-time fill limit
// Assumes: Push and pop may share a cycle, also when full
// Notes: Clear beats push and pop; head is the oldest entry
`timescale 1ns/1ps
module usm_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  parameter int CW = $clog2(DEPTH + 1),
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic clr_i,
  input wire logic [CW-1:0] limit_i,
  // Fill side
  input wire logic push_valid_i,
  input wire logic [W-1:0] push_data_i,
  output logic push_ready_o,
  // Drain side
  output logic pop_valid_o,
  input wire logic pop_ready_i,
  output logic [W-1:0] head_o,
  output logic [CW-1:0] count_o
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [CW-1:0] cnt;
  } usm_fifo_state_t;

  usm_fifo_state_t st;
  usm_fifo_state_t next_st;
  logic do_push;
  logic do_pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign pop_valid_o = (st.cnt != '0);
  assign do_pop = pop_valid_o && pop_ready_i;
  // A pop in the same cycle frees the slot, so a full FIFO may still overwrite
  assign push_ready_o = (st.cnt < limit_i) || do_pop;
  assign do_push = push_valid_i && push_ready_o;
  assign head_o = st.mem[st.rd];
  assign count_o = st.cnt;

  always_comb begin
    next_st = st;
    if (clr_i) begin
      next_st.rd = '0;
      next_st.wr = '0;
      next_st.cnt = '0;
    end else begin
      if (do_push) begin
        next_st.mem[st.wr] = push_data_i;
        next_st.wr = bump(st.wr);
      end
      if (do_pop) begin
        next_st.rd = bump(st.rd);
      end
      if (do_push && !do_pop) begin
        next_st.cnt = st.cnt + CW'(1);
      end else if (do_pop && !do_push) begin
        next_st.cnt = st.cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// [tb/usm_peer.sv]
// Purpose: Line-side peer driving the modem pins and the serial input
// Assumes: Active-low modem pins, line idles at mark level
// Notes: The bench changes pins through the tasks, right after an edge
`timescale 1ns/1ps
module usm_peer (
  // Modem pins towards the block
  output usm_pkg::usm_modem_in_t modem_o,
  // Serial line towards the block
  output logic line_o
);
  import usm_pkg::*;

  // Idle: every modem line inactive, line at mark
  initial begin
    modem_o = 4'hf;
    line_o = 1'b1;
  end

  task automatic set_modem(input logic [3:0] v);
    modem_o <= v;
  endtask

  task automatic set_line(input logic v);
    line_o <= v;
  endtask
endmodule

// [tb/usm_status_sva.sv]
// Purpose: Port assertions of the status, modem and FIFO control block
// Assumes: Bound into usm_status_ctrl, sees its ports only
// Notes: A shadow of modem control follows taken bus writes
`timescale 1ns/1ps
module usm_status_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Serial path
  input wire logic rx_serial_o,
  input wire logic tx_serial_i,
  input wire logic serial_in_pin_i,
  input wire logic serial_out_pin_o,
  // Modem, interrupt and mode outputs
  input wire logic rts_n_o,
  input wire logic dtr_n_o,
  input wire logic irq_req_i,
  input wire logic irq_o,
  input wire logic fifo_mode_o,
  input wire logic dma_mode_o
);
  logic take;
  logic [4:0] mc;

  // ==========================================================
  // Shadow of modem control, updated on the taking edge
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mc <= 5'h00;
    end else if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h10) begin
      mc <= wb_dat_i[4:0];
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================
  // Properties
  a_loop_serial_out_pin: assert property (mc[4] |-> serial_out_pin_o)
    else $error("serial output not held high in loopback");
  a_loop_rxpath: assert property (
    rx_serial_o == (mc[4] ? tx_serial_i : serial_in_pin_i))
    else $error("receiver fed from the wrong source");
  a_loop_modem: assert property (mc[4] |-> rts_n_o && dtr_n_o)
    else $error("modem outputs active in loopback");
  a_modem_drive: assert property (
    !mc[4] |-> rts_n_o == !mc[1] && dtr_n_o == !mc[0])
    else $error("modem outputs do not follow control bits");
  a_irq_gate: assert property (irq_o == (irq_req_i && mc[3] && !mc[4]))
    else $error("interrupt output gating wrong");
  a_fifo_write: assert property (
    take && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h08 |=>
    fifo_mode_o == $past(wb_dat_i[0]) &&
    dma_mode_o == ($past(wb_dat_i[0]) && $past(wb_dat_i[3])))
    else $error("fifo or dma mode not taken from control write");
  a_reset_state: assert property (
    $fell(rst_i) |-> rts_n_o && dtr_n_o && !fifo_mode_o && !dma_mode_o && !irq_o)
    else $error("outputs not idle after reset");
  a_ack_pulse: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge not a single cycle");
endmodule

bind usm_status_ctrl usm_status_sva u_usm_status_sva (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .rx_serial_o,
  .tx_serial_i, .serial_in_pin_i, .serial_out_pin_o, .rts_n_o, .dtr_n_o,
  .irq_req_i, .irq_o, .fifo_mode_o, .dma_mode_o);

// [tb/testbench.sv]
// Purpose: Self-checking bench of the status, modem and FIFO control block
// Assumes: Classic Wishbone, registers in byte lane 0
// Notes: Peer model owns the modem pins and the line input
`timescale 1ns/1ps
module testbench;
  import usm_pkg::*;
  localparam int DEPTH = 16;
  localparam logic [7:0] A_DAT = 8'h00;
  localparam logic [7:0] A_FC = 8'h08;
  localparam logic [7:0] A_MC = 8'h10;
  localparam logic [7:0] A_LS = 8'h14;
  localparam logic [7:0] A_MS = 8'h18;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic rxv = 1'b0;
  logic take = 1'b0;
  logic sidle = 1'b1;
  logic tser = 1'b1;
  logic irqen = 1'b1;
  logic ireq = 1'b0;
  logic [3:0] sel = 4'h1;
  logic [3:0] bsel = 4'h1;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  usm_rx_char_t rxc = '0;
  usm_modem_in_t modem;
  logic ack, rxs, txv, serial_in_pin, serial_out_pin, rts_n, dtr_n, evt, trig, irq, fmode, dmode;
  logic [7:0] txd, r;
  logic [31:0] dat_o;
  int err_total = 0;
  int checks = 0;
  int lv[4] = '{1, 4, 8, 14};

  always #5 clk_i = ~clk_i;

  usm_status_ctrl #(.DEPTH(DEPTH)) u_usm_status_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .rx_valid_i(rxv),
    .rx_char_i(rxc), .rx_serial_o(rxs), .tx_valid_o(txv), .tx_data_o(txd),
    .tx_take_i(take), .tx_shift_idle_i(sidle), .tx_serial_i(tser),
    .serial_in_pin_i(serial_in_pin), .serial_out_pin_o(serial_out_pin), .modem_i(modem),
    .rts_n_o(rts_n), .dtr_n_o(dtr_n), .tx_empty_irq_enable_i(irqen),
    .tx_empty_event_o(evt), .rx_trigger_o(trig), .irq_req_i(ireq), .irq_o(irq),
    .fifo_mode_o(fmode), .dma_mode_o(dmode));

  usm_peer u_usm_peer (.modem_o(modem), .line_o(serial_in_pin));

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Request held until the acknowledging edge, data taken there
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= bsel;
    adr <= a;
    dat <= {24'h00_0000, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    r = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(r, e);
  endtask

  task automatic push(input logic [2:0] e, input logic [7:0] d);
    @(posedge clk_i);
    rxv <= 1'b1;
    rxc <= {e, d};
    @(posedge clk_i);
    rxv <= 1'b0;
    @(negedge clk_i);
  endtask

  task automatic final_report();
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Whole run takes a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    final_report();
  end

  initial begin
    logic [2:0] e;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(A_LS, 8'h60);
    rc(A_MS, 8'h00);
    chk({6'h00, rts_n, dtr_n}, 8'h03);
    rc(8'h04, 8'h00);
    rc(8'h1c, 8'h00);
    wr(A_MC, 8'h01);
    chk({6'h00, rts_n, dtr_n}, 8'h02);
    wr(A_MC, 8'h02);
    chk({6'h00, rts_n, dtr_n}, 8'h01);
    rc(A_MC, 8'h02);
    // Write without byte lane 0 is acknowledged and dropped
    bsel = 4'he;
    wr(A_MC, 8'h01);
    bsel = 4'h1;
    rc(A_MC, 8'h02);
    chk({6'h00, rts_n, dtr_n}, 8'h01);
    // ==========================================================
    // Modem inputs and change flags
    u_usm_peer.set_modem(4'h0);
    repeat (3) @(posedge clk_i);
    rc(A_MS, 8'hfb);
    rc(A_MS, 8'hf0);
    u_usm_peer.set_modem(4'h4);
    repeat (3) @(posedge clk_i);
    rc(A_MS, 8'hb4);
    u_usm_peer.set_modem(4'h6);
    repeat (3) @(posedge clk_i);
    rc(A_MS, 8'h92);
    u_usm_peer.set_modem(4'hf);
    repeat (3) @(posedge clk_i);
    rc(A_MS, 8'h09);
    // ==========================================================
    // Loopback and interrupt gating
    wr(A_MC, 8'h15);
    tser <= 1'b0;
    bus(1'b0, A_MS, 8'h00);
    chk(r & 8'hf0, 8'h60);
    chk({4'h0, serial_out_pin, rxs, rts_n, dtr_n}, 8'h0b);
    wr(A_MC, 8'h1a);
    tser <= 1'b1;
    ireq <= 1'b1;
    bus(1'b0, A_MS, 8'h00);
    chk(r & 8'hf0, 8'h90);
    chk({3'h0, irq, serial_out_pin, rxs, rts_n, dtr_n}, 8'h0f);
    u_usm_peer.set_line(1'b0);
    wr(A_MC, 8'h08);
    chk({6'h00, irq, rxs}, 8'h02);
    wr(A_MC, 8'h00);
    chk({7'h00, irq}, 8'h00);
    ireq <= 1'b0;
    u_usm_peer.set_line(1'b1);
    bus(1'b0, A_MS, 8'h00);
    // ==========================================================
    // Receive errors and overrun, single holding register
    for (int i = 0; i < 3; i++) begin
      e = 3'h1 << i;
      push(e, 8'ha0 | 8'(i));
      rc(A_LS, 8'h61 | {3'h0, e, 2'h0});
      rc(A_LS, 8'h61);
      rc(A_DAT, 8'ha0 | 8'(i));
      rc(A_LS, 8'h60);
    end
    push(3'h0, 8'h11);
    push(3'h0, 8'h22);
    rc(A_LS, 8'h63);
    rc(A_LS, 8'h61);
    rc(A_DAT, 8'h22);
    // ==========================================================
    // Queue mode: head flags, summary flag, triggers
    wr(A_FC, 8'h01);
    chk({7'h00, fmode}, 8'h01);
    push(3'h0, 8'h31);
    push(3'h1, 8'h32);
    push(3'h0, 8'h33);
    rc(A_LS, 8'he1);
    rc(A_LS, 8'he1);
    rc(A_DAT, 8'h31);
    rc(A_LS, 8'he5);
    rc(A_DAT, 8'h32);
    rc(A_LS, 8'h61);
    rc(A_DAT, 8'h33);
    rc(A_LS, 8'h60);
    for (int s = 0; s < 4; s++) begin
      wr(A_FC, {2'(s), 6'h33});
      rc(A_LS, 8'h60);
      repeat (lv[s] - 1) push(3'h0, 8'h44);
      chk({7'h00, trig}, 8'h00);
      push(3'h0, 8'h44);
      chk({7'h00, trig}, 8'h01);
    end
    repeat (DEPTH - 13) push(3'h0, 8'h44);
    rc(A_LS, 8'h63);
    wr(A_FC, 8'h09);
    chk({6'h00, fmode, dmode}, 8'h03);
    wr(A_FC, 8'h08);
    chk({6'h00, fmode, dmode}, 8'h00);
    // ==========================================================
    // Transmit path, single holding register, then queue mode and transmit clear
    wr(A_DAT, 8'h5a);
    chk(txd, 8'h5a);
    rc(A_LS, 8'h00);
    @(posedge clk_i);
    take <= 1'b1;
    sidle <= 1'b0;
    @(negedge clk_i);
    chk({6'h00, txv, evt}, 8'h03);
    @(posedge clk_i);
    take <= 1'b0;
    rc(A_LS, 8'h20);
    sidle <= 1'b1;
    rc(A_LS, 8'h60);
    // Drain with the event enable low raises no event
    irqen <= 1'b0;
    wr(A_DAT, 8'h5b);
    @(posedge clk_i);
    take <= 1'b1;
    @(negedge clk_i);
    chk({6'h00, txv, evt}, 8'h02);
    @(posedge clk_i);
    take <= 1'b0;
    irqen <= 1'b1;
    rc(A_LS, 8'h60);
    wr(A_FC, 8'h01);
    wr(A_DAT, 8'h61);
    wr(A_DAT, 8'h62);
    rc(A_LS, 8'h00);
    wr(A_FC, 8'h05);
    chk({7'h00, txv}, 8'h00);
    rc(A_LS, 8'h60);
    // ==========================================================
    // Reset in mid-run
    wr(A_MC, 8'h03);
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({5'h00, fmode, rts_n, dtr_n}, 8'h03);
    rc(A_LS, 8'h60);
    final_report();
  end
endmodule
